// ===== verilog/timer_ir_carrier_unit.sv
// Summary of operation
// - timer c scale divides by 2^(sel+1)
// - scale enable low means timer c 1:1
// - timer a 8-bit, read/write, reset clears
// - timer a ticks per instruction tick
// - timer b low 8-bit, read/write, reset clears
// - timer b high used only when extended
// - extended timer b carries low into high
// - 8-bit timer b leaves high byte alone
// - carrier mode only if enable and application
// - up mode overflows after ratio times remainder
// - carrier period twice (1+value) times ratio
// - system tick full or half oscillator rate
// - output low (1+low value) times ratio
// - output high (1+high value) times ratio
// - low underflow interrupt vectors to 015h
// - high underflow interrupt vectors to 012h
// - mask holds one enable per source
// - request needs flag, mask and global enable
// - width scales 1:1 or 2^(sel+1)
// - width underflows set flags, software clears
`default_nettype none
module timer_ir_carrier_unit
  import ir_timer_pkg::*;
(
  input  wire logic        CLOCK_IN,
  input  wire logic        RST_B_IN,
  input  wire logic        HSEL_IN,
  input  wire logic [31:0] HADDR_IN,
  input  wire logic [1:0]  HTRANS_IN,
  input  wire logic        HWRITE_IN,
  input  wire logic [2:0]  HSIZE_IN,
  input  wire logic [31:0] HWDATA_IN,
  input  wire logic        HREADY_IN,
  output logic      [31:0] HRDATA_OUT,
  output logic             HREADYOUT_OUT,
  output logic             HRESP_OUT,
  input  wire logic        EXT_PIN_EVENT_IN,
  input  wire logic        PORT_CHANGE_EVENT_IN,
  input  wire logic        MAIN_TIMER_EVENT_IN,
  output logic             IRQ_OUT,
  output logic      [7:0]  IRQ_VECTOR_OUT,
  output logic             IR_PIN_OUT,
  output logic             IR_PIN_OE_OUT
);

  // true when a prescaler count completes its ratio
  function automatic logic scale_hit(input logic [7:0] cnt,
                                     input logic en,
                                     input logic [2:0] sel);
    logic [8:0] m;
    m = (9'h002 << sel) - 9'h001;
    return !en || ((cnt & m[7:0]) == m[7:0]);
  endfunction

  // bus data phase state
  logic        dp_valid_r;   // a transfer is in data phase
  logic        dp_write_r;   // that transfer writes
  logic [7:0]  dp_addr_r;    // its byte offset
  logic        rd_done_r;    // read wait state spent
  logic [31:0] hrdata_r;     // captured read word
  // software registers
  logic [7:0]  ir_ctl_r;
  logic [7:0]  mask_r;
  logic [7:0]  ta_r;
  logic [7:0]  tbl_r;
  logic [7:0]  tbh_r;
  logic [7:0]  tc_r;
  logic [7:0]  low_r;
  logic [7:0]  high_r;
  logic [7:0]  tscale_r;
  logic [7:0]  tctl_r;
  logic [7:0]  flags_r;      // sticky requests
  logic        gie_r;        // global enable
  // engine state
  logic        half_r;       // clock option divider
  logic [7:0]  tc_pre_r;     // timer c prescaler
  logic [7:0]  seg_pre_r;    // width prescaler
  logic [7:0]  wcnt_r;       // width down counter
  seg_e        seg_r;
  logic [7:0]  car_cnt_r;    // carrier half period count
  logic        carrier_r;
  logic        ir_pin_r;
  logic        ir_oe_r;
  logic        irq_r;
  logic [7:0]  vec_r;

  // field views
  ir_ctl_s     ir_ctl;
  time_scale_s tscale;
  timer_ctl_s  tctl;
  assign ir_ctl = ir_ctl_s'(ir_ctl_r);
  assign tscale = time_scale_s'(tscale_r);
  assign tctl   = timer_ctl_s'(tctl_r);

  // address phase decode; only whole-word singles expected
  wire accept     = HSEL_IN & HTRANS_IN[1] & HREADY_IN;
  wire read_stall = dp_valid_r & ~dp_write_r & ~rd_done_r;
  wire wr_en      = dp_valid_r & dp_write_r;
  wire [7:0] wd   = HWDATA_IN[7:0];
  wire wr_ir_ctl  = wr_en && (dp_addr_r == OFS_IR_CTL);
  wire wr_mask    = wr_en && (dp_addr_r == OFS_IRQ_MASK);
  wire wr_ta      = wr_en && (dp_addr_r == OFS_TIMER_A);
  wire wr_tbl     = wr_en && (dp_addr_r == OFS_TIMER_B_LOW);
  wire wr_tbh     = wr_en && (dp_addr_r == OFS_TIMER_B_HIGH);
  wire wr_tc      = wr_en && (dp_addr_r == OFS_TIMER_C);
  wire wr_low     = wr_en && (dp_addr_r == OFS_LOW_TIME);
  wire wr_high    = wr_en && (dp_addr_r == OFS_HIGH_TIME);
  wire wr_tscale  = wr_en && (dp_addr_r == OFS_TIME_SCALE);
  wire wr_tctl    = wr_en && (dp_addr_r == OFS_TIMER_CTL);
  wire wr_flags   = wr_en && (dp_addr_r == OFS_IRQ_FLAGS);
  wire wr_gie     = wr_en && (dp_addr_r == OFS_GLOBAL_IRQ);

  // read selection; flags read back gated by the mask
  logic [7:0] rd_byte;
  always_comb begin
    unique case (dp_addr_r)
      OFS_IR_CTL:       rd_byte = ir_ctl_r;
      OFS_IRQ_MASK:     rd_byte = mask_r;
      OFS_TIMER_A:      rd_byte = ta_r;
      OFS_TIMER_B_LOW:  rd_byte = tbl_r;
      OFS_TIMER_B_HIGH: rd_byte = tbh_r;
      OFS_TIMER_C:      rd_byte = tc_r;
      OFS_LOW_TIME:     rd_byte = low_r;
      OFS_HIGH_TIME:    rd_byte = high_r;
      OFS_TIME_SCALE:   rd_byte = tscale_r;
      OFS_TIMER_CTL:    rd_byte = tctl_r;
      OFS_IRQ_FLAGS:    rd_byte = flags_r & mask_r;
      OFS_GLOBAL_IRQ:   rd_byte = {7'h00, gie_r};
      default:          rd_byte = 8'h00; // unmapped reads zero
    endcase
  end

  // bus phase tracking; one wait state on reads so data is registered
  always_ff @(posedge CLOCK_IN) begin
    if (!RST_B_IN) begin
      dp_valid_r <= 1'b0;
      dp_write_r <= 1'b0;
      dp_addr_r  <= 8'h00;
      rd_done_r  <= 1'b0;
      hrdata_r   <= 32'h0000_0000;
    end else if (HREADY_IN) begin
      dp_valid_r <= accept;
      dp_write_r <= HWRITE_IN;
      dp_addr_r  <= HADDR_IN[7:0];
      rd_done_r  <= 1'b0;
    end else if (read_stall) begin
      rd_done_r <= 1'b1;
      hrdata_r  <= {24'h00_0000, rd_byte};
    end
  end
  assign HREADYOUT_OUT = ~read_stall;
  assign HRESP_OUT     = 1'b0; // always okay
  assign HRDATA_OUT    = hrdata_r;

  // system tick: every cycle, or every second one on the four-clock option
  wire tick = ~tctl.four_clk | half_r;

  // timer c prescaler hit, and the width prescaler hit of the active segment
  wire tc_hit  = tick && scale_hit(tc_pre_r, ir_ctl.tc_scale_en, ir_ctl.tc_scale_sel);
  wire seg_hit = tick && (seg_r == SEG_LOW
                 ? scale_hit(seg_pre_r, tscale.lo_scale_en, tscale.lo_scale_sel)
                 : scale_hit(seg_pre_r, tscale.hi_scale_en, tscale.hi_scale_sel));
  wire ir_mode = ir_ctl.ir_en & ir_ctl.ir_app;

  // overflow and underflow events
  wire a_run  = tctl.a_en & tick & ~wr_ta;
  wire a_ovf  = a_run && (ta_r == COUNT_MAX);
  wire b_run  = tctl.b_en & tick & ~wr_tbl & ~(tctl.b_extend & wr_tbh);
  wire b_wrap = (tbl_r == COUNT_MAX) && (!tctl.b_extend || tbh_r == COUNT_MAX);
  wire b_ovf  = b_run && b_wrap;
  wire c_run  = tctl.c_en & ~ir_mode & tc_hit & ~wr_tc;
  wire c_ovf  = c_run && (tc_r == COUNT_MAX);
  wire w_under = ir_ctl.ir_en && seg_hit && (wcnt_r == 8'h00);
  wire lo_under = w_under && (seg_r == SEG_LOW);
  wire hi_under = w_under && (seg_r == SEG_HIGH);

  // hardware sets win over software clears
  logic [7:0] flag_set;
  assign flag_set = {lo_under, hi_under, c_ovf, b_ovf, a_ovf,
                     EXT_PIN_EVENT_IN, PORT_CHANGE_EVENT_IN, MAIN_TIMER_EVENT_IN};
  wire [7:0] flag_keep = wr_flags ? (flags_r & wd) : flags_r;   // write 0 clears
  wire [7:0] flags_nxt = flag_keep | flag_set;

  // control and mask registers
  always_ff @(posedge CLOCK_IN) begin
    if (!RST_B_IN) begin
      ir_ctl_r <= RST_BYTE;
      mask_r   <= RST_BYTE;
      low_r    <= RST_BYTE;
      high_r   <= RST_BYTE;
      tscale_r <= RST_BYTE;
      tctl_r   <= RST_BYTE;
      flags_r  <= RST_BYTE;
      gie_r    <= 1'b0;
    end else begin
      if (wr_ir_ctl) ir_ctl_r <= wd;
      if (wr_mask) mask_r <= wd;
      if (wr_low) low_r <= wd;
      if (wr_high) high_r <= wd;
      if (wr_tscale) tscale_r <= wd;
      if (wr_tctl) tctl_r <= {3'b000, wd[4:0]};
      if (wr_gie) gie_r <= wd[0]; // 1 acts as enable, 0 as disable
      flags_r <= flags_nxt;
    end
  end

  // timers a and b; a bus write beats a same-cycle increment
  always_ff @(posedge CLOCK_IN) begin
    if (!RST_B_IN) begin
      half_r <= 1'b0;
      ta_r   <= RST_BYTE;
      tbl_r  <= RST_BYTE;
      tbh_r  <= RST_BYTE;
    end else begin
      half_r <= ~half_r;
      if (wr_ta) ta_r <= wd;
      else if (a_run) ta_r <= ta_r + 8'h01;
      if (wr_tbl) tbl_r <= wd;
      else if (b_run) tbl_r <= tbl_r + 8'h01;
      if (wr_tbh) tbh_r <= wd;
      else if (b_run && tctl.b_extend && tbl_r == COUNT_MAX) tbh_r <= tbh_r + 8'h01;
    end
  end

  // timer c: up counter, or carrier generator in infrared mode
  always_ff @(posedge CLOCK_IN) begin
    if (!RST_B_IN) begin
      tc_r      <= RST_BYTE;
      tc_pre_r  <= RST_BYTE;
      car_cnt_r <= RST_BYTE;
      carrier_r <= 1'b0;
    end else begin
      if (wr_tc) begin
        tc_r     <= wd;
        tc_pre_r <= 8'h00; // restart ratio so the first period is whole
      end else begin
        if (c_run) tc_r <= tc_r + 8'h01;
        if (tick && (tctl.c_en || ir_mode)) tc_pre_r <= tc_pre_r + 8'h01;
      end
      if (!ir_mode) begin
        car_cnt_r <= 8'h00;
        carrier_r <= 1'b0;
      end else if (tc_hit) begin
        // half period is (1+value) scaled ticks
        if (car_cnt_r == tc_r) begin
          car_cnt_r <= 8'h00;
          carrier_r <= ~carrier_r;
        end else begin
          car_cnt_r <= car_cnt_r + 8'h01;
        end
      end
    end
  end

  // width counters: low segment, then high, unless long pulse holds low
  always_ff @(posedge CLOCK_IN) begin
    if (!RST_B_IN) begin
      seg_r     <= SEG_LOW;
      wcnt_r    <= RST_BYTE;
      seg_pre_r <= RST_BYTE;
    end else if (!ir_ctl.ir_en) begin
      seg_r     <= SEG_LOW;
      wcnt_r    <= low_r;
      seg_pre_r <= 8'h00;
    end else if (w_under) begin
      seg_pre_r <= 8'h00;
      if (seg_r == SEG_LOW && !ir_ctl.long_pulse) begin
        seg_r  <= SEG_HIGH;
        wcnt_r <= high_r;
      end else begin
        seg_r  <= SEG_LOW;
        wcnt_r <= low_r;
      end
    end else if (tick) begin
      seg_pre_r <= seg_pre_r + 8'h01;
      if (seg_hit) wcnt_r <= wcnt_r - 8'h01;
    end
  end

  // pin: low segment active low, carrier-gated in the ir application
  wire pin_nxt = (seg_r == SEG_HIGH) ? 1'b1 : (ir_ctl.ir_app ? carrier_r : 1'b0);
  wire [7:0] pending = flags_nxt & mask_r;
  always_ff @(posedge CLOCK_IN) begin
    if (!RST_B_IN) begin
      ir_pin_r <= 1'b1;
      ir_oe_r  <= 1'b0;
      irq_r    <= 1'b0;
      vec_r    <= VEC_OTHER;
    end else begin
      ir_pin_r <= ir_ctl.ir_en ? pin_nxt : 1'b1;
      ir_oe_r  <= ir_ctl.ir_en & ir_ctl.ir_pin_en;
      irq_r    <= gie_r && (pending != 8'h00);
      // low width outranks high width
      if (pending[BIT_LOW_WIDTH]) vec_r <= VEC_LOW_WIDTH;
      else if (pending[BIT_HIGH_WIDTH]) vec_r <= VEC_HIGH_WIDTH;
      else vec_r <= VEC_OTHER;
    end
  end
  assign IR_PIN_OUT     = ir_pin_r;
  assign IR_PIN_OE_OUT  = ir_oe_r;
  assign IRQ_OUT        = irq_r;
  assign IRQ_VECTOR_OUT = vec_r;

  // carrier check helper: times each carrier level in whole cycles
  logic       car_prev_r;  // carrier one cycle ago
  logic [8:0] car_run_r;   // cycles spent at the current carrier level
  logic       car_clean_r; // a run began with the settings left alone
  wire car_flip  = carrier_r != car_prev_r;
  // any of these spoils the timing of the run in progress
  wire car_upset = !ir_mode | wr_tc | wr_ir_ctl | wr_tctl;
  always_ff @(posedge CLOCK_IN) begin
    if (!RST_B_IN) begin
      car_prev_r  <= 1'b0;
      car_run_r   <= 9'h000;
      car_clean_r <= 1'b0;
    end else begin
      car_prev_r  <= carrier_r;
      car_run_r   <= car_flip ? 9'h001 : car_run_r + 9'h001;
      car_clean_r <= car_upset ? 1'b0 : (car_flip | car_clean_r);
    end
  end

  default clocking cb @(posedge CLOCK_IN); endclocking
  default disable iff (!RST_B_IN);

  AST_TA_WRAP: assert property (a_ovf |=> ta_r == 8'h00 && flags_r[BIT_TIMER_A])
    else $error("timer a did not wrap with flag");
  AST_TB8_HOLD: assert property (b_ovf && !tctl.b_extend && !wr_tbh
    |=> tbl_r == 8'h00 && tbh_r == $past(tbh_r))
    else $error("8-bit timer b touched high byte");
  AST_TB16_WRAP: assert property (b_ovf && tctl.b_extend |=> {tbh_r, tbl_r} == 16'h0000)
    else $error("16-bit timer b did not wrap");
  AST_TC_UNSCALED: assert property (!ir_ctl.tc_scale_en |-> tc_hit == tick)
    else $error("unscaled timer c not 1:1");
  AST_TC_RATIO2: assert property (ir_ctl.tc_scale_en && ir_ctl.tc_scale_sel == 3'd0 && tc_hit
    |-> tc_pre_r[0])
    else $error("timer c 1:2 ratio broken");
  AST_HALF_RATE: assert property (tctl.four_clk && tick && !wr_tctl |=> !tick)
    else $error("four-clock tick ran full rate");
  AST_LOW_FLAG: assert property (lo_under |=> flags_r[BIT_LOW_WIDTH])
    else $error("low underflow flag not set");
  AST_IRQ_GATE: assert property (gie_r && (pending != 8'h00) |=> IRQ_OUT)
    else $error("enabled request not raised");
  AST_LOW_VEC: assert property (pending[BIT_LOW_WIDTH] |=> IRQ_VECTOR_OUT == VEC_LOW_WIDTH)
    else $error("low width vector wrong");
  AST_NO_CARRIER: assert property (!ir_mode |=> !carrier_r)
    else $error("carrier ran outside ir mode");
  // unscaled full-rate carrier: each level lasts one plus the timer c value
  AST_CARRIER_HALF: assert property (car_clean_r && car_flip && ir_mode
    && !ir_ctl.tc_scale_en && !tctl.four_clk |-> car_run_r == {1'b0, tc_r} + 9'h001)
    else $error("carrier half period wrong");
  AST_TC_WRAP: assert property (c_ovf |=> tc_r == 8'h00 && flags_r[BIT_TIMER_C])
    else $error("timer c did not wrap with flag");
  AST_TC_IR_HOLD: assert property (ir_mode && !wr_tc |=> tc_r == $past(tc_r))
    else $error("timer c counted in ir mode");
  AST_TA_STEP: assert property (a_run && !a_ovf |=> ta_r == $past(ta_r) + 8'h01)
    else $error("timer a missed a tick");
  AST_HIGH_FLAG: assert property (hi_under |=> flags_r[BIT_HIGH_WIDTH])
    else $error("high underflow flag not set");
  AST_HIGH_VEC: assert property (!pending[BIT_LOW_WIDTH] && pending[BIT_HIGH_WIDTH]
    |=> IRQ_VECTOR_OUT == VEC_HIGH_WIDTH)
    else $error("high width vector wrong");
  AST_IRQ_QUIET: assert property (!gie_r |=> !IRQ_OUT)
    else $error("request raised while globally off");
  AST_PIN_IDLE: assert property (!ir_ctl.ir_en |=> IR_PIN_OUT)
    else $error("pin not idle high");
  AST_PIN_HIGH_SEG: assert property (ir_ctl.ir_en && seg_r == SEG_HIGH |=> IR_PIN_OUT)
    else $error("pin low in high segment");
  AST_OE_OFF: assert property (!ir_ctl.ir_pin_en |=> !IR_PIN_OE_OUT)
    else $error("pin driven while not routed");

endmodule
`default_nettype wire

// ===== verilog/ir_timer_pkg.sv
`default_nettype none
package ir_timer_pkg;
  // byte offsets of the register map on the ahb-lite port
  localparam logic [7:0] OFS_IR_CTL = 8'h00;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h04;
  localparam logic [7:0] OFS_TIMER_A = 8'h08;
  localparam logic [7:0] OFS_TIMER_B_LOW = 8'h0c;
  localparam logic [7:0] OFS_TIMER_B_HIGH = 8'h10;
  localparam logic [7:0] OFS_TIMER_C = 8'h14;
  localparam logic [7:0] OFS_LOW_TIME = 8'h18;
  localparam logic [7:0] OFS_HIGH_TIME = 8'h1c;
  localparam logic [7:0] OFS_TIME_SCALE = 8'h20;
  localparam logic [7:0] OFS_TIMER_CTL = 8'h24;
  localparam logic [7:0] OFS_IRQ_FLAGS = 8'h28;
  localparam logic [7:0] OFS_GLOBAL_IRQ = 8'h2c;
  // value of every register after reset
  localparam logic [7:0] RST_BYTE = 8'h00;
  // interrupt flag and mask bit positions
  localparam int BIT_LOW_WIDTH = 7;
  localparam int BIT_HIGH_WIDTH = 6;
  localparam int BIT_TIMER_C = 5;
  localparam int BIT_TIMER_B = 4;
  localparam int BIT_TIMER_A = 3;
  localparam int BIT_EXT_PIN = 2;
  localparam int BIT_PORT_CHG = 1;
  localparam int BIT_MAIN_TMR = 0;
  // fetch vectors handed to the core
  localparam logic [7:0] VEC_LOW_WIDTH = 8'h15;
  localparam logic [7:0] VEC_HIGH_WIDTH = 8'h12;
  localparam logic [7:0] VEC_OTHER = 8'h00; // arbitrary value
  localparam logic [7:0] COUNT_MAX = 8'hff;
  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
  // ir and timer c scale control layout
  typedef struct packed {
    logic       tc_scale_en;  // timer_c_scale_enable
    logic [2:0] tc_scale_sel; // timer_c_scale_select
    logic       ir_en;        // infrared_enable
    logic       ir_app;       // infrared_application_select
    logic       long_pulse;   // high time ignored
    logic       ir_pin_en;    // pin driven by modulator
  } ir_ctl_s;
  // high/low time scale control layout
  typedef struct packed {
    logic       hi_scale_en;  // high_time_scale_enable
    logic [2:0] hi_scale_sel;
    logic       lo_scale_en;  // low_time_scale_enable
    logic [2:0] lo_scale_sel;
  } time_scale_s;
  // timer enables and clock option
  typedef struct packed {
    logic [2:0] unused;
    logic       four_clk;     // 1: system_tick = half rate
    logic       b_extend;     // timer_b_extend_enable
    logic       c_en;
    logic       b_en;
    logic       a_en;
  } timer_ctl_s;
  // active pulse segment of the modulator
  typedef enum logic {SEG_LOW = 1'b0, SEG_HIGH = 1'b1} seg_e;
endpackage
`default_nettype wire

// ===== test/ir_emitter_model.sv
`default_nettype none
// emitter on the ir pin: logs the length of each lit and dark run
module ir_emitter_model (
  input  wire logic        clk_in,
  input  wire logic        pin_in,
  input  wire logic        oe_in,
  output logic      [15:0] low_w_out,
  output logic      [15:0] high_w_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] run_r = 16'h0000; // cycles at the current level
  logic        lvl_r = 1'b1;     // level seen last cycle
  // a floating pin lights nothing, so runs restart while undriven
  always @(posedge clk_in) begin
    if (oe_in !== 1'b1) begin
      run_r <= 16'h0000;
    end else if (pin_in !== lvl_r) begin
      if (lvl_r === 1'b1) begin
        high_w_out <= run_r;
      end else begin
        low_w_out <= run_r;
      end
      run_r <= 16'h0001;
    end else begin
      run_r <= run_r + 16'h0001;
    end
    lvl_r <= pin_in;
  end
endmodule
`default_nettype wire

// ===== test/timer_ir_carrier_unit_tb.sv
`default_nettype none
module timer_ir_carrier_unit_tb;
  import ir_timer_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk;         // 25 mhz system clock
  logic        rst_b;       // sync reset, low active
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [31:0] hwdata;
  logic [2:0]  ev;          // ext, port, main event pulses
  logic [31:0] hrdata;
  logic        hready;
  logic        hresp;
  logic        irq;
  logic [7:0]  vec;
  logic        pin;
  logic        oe;
  logic [15:0] low_w;       // last lit run seen by the emitter
  logic [15:0] high_w;      // last dark run
  logic [31:0] exp_q[$];    // expected read data, oldest first
  logic        rd_dp = 1'b0; // read data phase in flight
  int          err_total = 0;
  int          total_checks = 0;

  timer_ir_carrier_unit dut_u (
    .CLOCK_IN            (clk),
    .RST_B_IN            (rst_b),
    .HSEL_IN             (1'b1),
    .HADDR_IN            (haddr),
    .HTRANS_IN           (htrans),
    .HWRITE_IN           (hwrite),
    .HSIZE_IN            (3'b010),
    .HWDATA_IN           (hwdata),
    .HREADY_IN           (hready),
    .HRDATA_OUT          (hrdata),
    .HREADYOUT_OUT       (hready),
    .HRESP_OUT           (hresp),
    .EXT_PIN_EVENT_IN    (ev[2]),
    .PORT_CHANGE_EVENT_IN(ev[1]),
    .MAIN_TIMER_EVENT_IN (ev[0]),
    .IRQ_OUT             (irq),
    .IRQ_VECTOR_OUT      (vec),
    .IR_PIN_OUT          (pin),
    .IR_PIN_OE_OUT       (oe)
  );

  ir_emitter_model emit_u (
    .clk_in    (clk),
    .pin_in    (pin),
    .oe_in     (oe),
    .low_w_out (low_w),
    .high_w_out(high_w)
  );

  // free running clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic stop_test();
    if (err_total == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  // ready is read mid cycle, where it already shows the value of the next edge
  task automatic wait_rdy();
    logic ok;
    do begin
      @(negedge clk);
      ok = hready;
      @(posedge clk);
    end while (ok !== 1'b1);
  endtask

  // one single word transfer, address phase then data phase
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    haddr  <= {24'h000000, a};
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    wait_rdy();
    htrans <= 2'b00;
    hwdata <= d;
    wait_rdy();
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, {24'h000000, d});
  endtask

  // note the expectation, the monitor checks it
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back({24'h000000, e});
    bus(1'b0, a, 32'h00000000);
  endtask

  // monitor: read data stands in the cycle where ready comes back
  always @(negedge clk) begin
    if (rd_dp && hready === 1'b1) begin
      cmp(hrdata, exp_q.pop_front());
    end
    if (hready === 1'b1) begin
      rd_dp = htrans[1] & ~hwrite;
    end
  end

  // watchdog, far beyond the twelve hundred or so cycles needed
  initial begin
    #800000;
    err_total++;
    stop_test();
  end

  initial begin
    logic [7:0]  r;
    logic [15:0] m;
    rst_b  = 1'b0;
    haddr  = 32'h00000000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hwdata = 32'h00000000;
    ev     = 3'b000;
    r      = 8'($urandom(79934));
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    // unmapped write must vanish; every place reads zero
    wr(8'h30, 8'ha5);
    for (int i = 0; i < 13; i++) begin
      rd(8'(i * 4), RST_BYTE);
    end
    // random read back while all timers stand
    for (int i = 1; i < 8; i++) begin
      r = 8'($urandom());
      wr(8'(i * 4), r);
      rd(8'(i * 4), r);
    end
    // timer a wraps from fe, request then masked off
    wr(OFS_IRQ_MASK, 8'h08);
    wr(OFS_TIMER_A, 8'hfe);
    wr(OFS_TIMER_CTL, 8'h01);
    cyc(6);
    rd(OFS_IRQ_FLAGS, 8'h08);
    wr(OFS_GLOBAL_IRQ, 8'h01);
    cyc(3);
    cmp(32'(irq), 32'h1);
    wr(OFS_IRQ_MASK, 8'h00);
    cyc(3);
    cmp(32'(irq), 32'h0);
    // timer b in 8-bit mode: high byte untouched
    wr(OFS_TIMER_CTL, 8'h00);
    wr(OFS_IRQ_FLAGS, 8'h00);
    wr(OFS_IRQ_MASK, 8'hff);
    rd(OFS_IRQ_FLAGS, 8'h00);
    wr(OFS_TIMER_B_HIGH, 8'h00);
    wr(OFS_TIMER_B_LOW, 8'hfe);
    wr(OFS_TIMER_CTL, 8'h02);
    cyc(6);
    rd(OFS_IRQ_FLAGS, 8'h10);
    wr(OFS_TIMER_CTL, 8'h00);
    rd(OFS_TIMER_B_HIGH, 8'h00);
    // 16-bit mode from fe00: wraps after 512 ticks, not 256
    wr(OFS_IRQ_FLAGS, 8'h00);
    wr(OFS_TIMER_B_HIGH, 8'hfe);
    wr(OFS_TIMER_B_LOW, 8'h00);
    wr(OFS_TIMER_CTL, 8'h0a);
    cyc(300);
    rd(OFS_IRQ_FLAGS, 8'h00);
    cyc(250);
    rd(OFS_IRQ_FLAGS, 8'h10);
    // timer c at 1:2 from f0: 32 ticks to wrap
    wr(OFS_TIMER_CTL, 8'h00);
    wr(OFS_IRQ_FLAGS, 8'h00);
    wr(OFS_IR_CTL, 8'h80);
    wr(OFS_TIMER_C, 8'hf0);
    wr(OFS_TIMER_CTL, 8'h04);
    cyc(18);
    rd(OFS_IRQ_FLAGS, 8'h00);
    cyc(20);
    rd(OFS_IRQ_FLAGS, 8'h20);
    // pulse widths: plain, half rate tick, width scale 1:4
    wr(OFS_TIMER_CTL, 8'h00);
    wr(OFS_LOW_TIME, 8'h03);
    wr(OFS_HIGH_TIME, 8'h05);
    wr(OFS_IRQ_MASK, 8'hc0);
    wr(OFS_GLOBAL_IRQ, 8'h01);
    for (int k = 0; k < 3; k++) begin
      m = 16'h0001 << k;
      wr(OFS_TIME_SCALE, (k == 2) ? 8'h99 : 8'h00);
      wr(OFS_TIMER_CTL, (k == 1) ? 8'h10 : 8'h00);
      wr(OFS_IR_CTL, 8'h09);
      cyc(100);
      cmp(32'(low_w), 32'(16'd4 * m));
      cmp(32'(high_w), 32'(16'd6 * m));
      wr(OFS_IR_CTL, 8'h00);
    end
    // carrier mode in a long low segment: pin follows the carrier, 3 cycles a level
    wr(OFS_LOW_TIME, 8'h3f);
    wr(OFS_TIMER_C, 8'h02);
    wr(OFS_IR_CTL, 8'h0d);
    cyc(40);
    cmp(32'(low_w), 32'h3);
    cmp(32'(high_w), 32'h3);
    wr(OFS_IR_CTL, 8'h00);
    // both width flags up: low width wins the vector
    cyc(3);
    cmp(32'(vec), 32'(VEC_LOW_WIDTH));
    cmp(32'(irq), 32'h1);
    wr(OFS_IRQ_FLAGS, 8'h7f);
    cyc(3);
    cmp(32'(vec), 32'(VEC_HIGH_WIDTH));
    // outside events, read back through the mask
    wr(OFS_IRQ_FLAGS, 8'h00);
    wr(OFS_IRQ_MASK, 8'h05);
    ev <= 3'b111;
    @(posedge clk);
    ev <= 3'b000;
    cyc(2);
    rd(OFS_IRQ_FLAGS, 8'h05);
    wr(OFS_IRQ_MASK, 8'hff);
    rd(OFS_IRQ_FLAGS, 8'h07);
    wr(OFS_IRQ_FLAGS, 8'h00);
    rd(OFS_IRQ_FLAGS, 8'h00);
    cmp(32'(hresp), 32'h0);
    cyc(2);
    stop_test();
  end
endmodule
`default_nettype wire
